// [vfd_keyscan_readout_dimming_tb.sv]
// Self-checking bench for both link ends and the host registers
`timescale 1ns/1ps
module vfd_keyscan_readout_dimming_tb;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [5:0]  colIn;
  logic [4:0]  rowOut;
  logic [29:0] segOut;
  logic [1:0]  gridOut;
  logic        pressed;
  logic [31:0] rdata;
  logic        rerr;
  logic [3:0]  modes [4] = '{4'h7, 4'h6, 4'h9, 4'h8};
  int          badCount;
  int          numChecks;
  int          n;

  vfdk_link_if link ();
  vfdk_host vfdk_host_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link.host));
  vfdk_device vfdk_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link.dev),
    .parkLevelIn(1'b1), .dimThresholdIn(6'h34), .colIn(colIn), .rowOut(rowOut),
    .segmentOut(segOut), .outputA(gridOut));
  vfdk_link_props vfdk_link_props_inst (.core_clk(core_clk), .rst_n(rst_n),
    .cs(link.cs), .sclk(link.sclk), .hostData(link.hostData),
    .hostOe(link.hostOe), .devOe(link.devOe));

  ////////////////////////////////
  // Clock and key at row 2, column 3
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    colIn <= (pressed && rowOut[2]) ? 6'h08 : 6'h00;
  end

  ////////////////////////////////
  // One APB transfer, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      badCount++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Command, wait for done, clear done
  task automatic run_cmd(input logic [31:0] c);
    apb(1'b1, vfdk_pkg::REG_CMD, c);
    do begin
      apb(1'b0, vfdk_pkg::REG_STATUS, 32'h0);
    end while (rdata[0] !== 1'b1);
    apb(1'b1, vfdk_pkg::REG_STATUS, 32'h1);
  endtask

  // Key-output command, then compare keys
  task automatic key_read(input logic [3:0] m, input logic [31:0] e);
    run_cmd({28'h0000000, m});
    apb(1'b0, vfdk_pkg::REG_KEYS, 32'h0);
    chk(rdata, e);
  endtask

  task automatic report_and_stop;
    if (badCount == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    colIn = 6'h00;
    pressed = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, vfdk_pkg::REG_STATUS, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, vfdk_pkg::REG_MASK, 32'h2);
    apb(1'b0, vfdk_pkg::REG_MASK, 32'h0);
    chk(rdata, 32'h2);
    apb(1'b1, vfdk_pkg::REG_DISPLO, 32'h12345678);
    foreach (modes[i]) begin
      key_read(modes[i], 32'h0);
    end
    chk({2'h0, segOut}, 32'h12345678);
    chk({30'h0, gridOut}, 32'h1);
    run_cmd(32'h00000001);
    chk({30'h0, gridOut}, 32'h0);
    run_cmd(32'h00000003);
    chk({30'h0, gridOut}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // Let the idle scan take a fresh key reference after the stops
    repeat (vfdk_pkg::BIT_CYC * vfdk_pkg::ROW_UNITS) @(posedge core_clk);
    pressed <= 1'b1;
    for (n = 0; n < 70000 && irq !== 1'b1; n++) begin
      @(posedge core_clk);
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, vfdk_pkg::REG_STATUS, 32'h0);
    chk(rdata & 32'h3, 32'h2);
    key_read(4'h8, 32'h8000);
    chk({31'h0, link.keyInt}, 32'h0);
    apb(1'b1, vfdk_pkg::REG_STATUS, 32'h2);
    apb(1'b0, vfdk_pkg::REG_STATUS, 32'h0);
    chk(rdata & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    report_and_stop;
  end

  // Hang guard
  initial begin
    #800us;
    badCount++;
    report_and_stop;
  end
endmodule

// [vfdk_device.sv]
// Display device end: serial receiver, key scanner, key readout, dimming
//
// Function
// RULE_01 - Key output mode turns data pin to output
// RULE_02 - Shift 30 key bits on rising clocks
// RULE_03 - After 30 bits, return on chip-select fall
// RULE_04 - Host always reads keys after stop
// RULE_05 - Stop frame 16 bits, mode last
// RULE_06 - Output order key 00 first, 45 last
// RULE_07 - Key change before stop: brief pause, resume
// RULE_08 - Drive rows, sample columns, row-column numbering
// RULE_09 - Segment n shows bit n or n+30
// RULE_10 - Digital on-time from 11-bit dim value
// RULE_11 - Digital on-time capped at 2032 of 2048
// RULE_12 - Analog steps out of 2048, top 256
// RULE_13 - Scan starts on key change; interrupt after cycle
// RULE_14 - Mode codes select keyscan output and stop
// RULE_15 - Sample while select high, latch on fall
// RULE_16 - Release data pin on select fall
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module vfdk_device (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Serial link
  vfdk_link_if.dev         link,
  // Dimming controls
  input  wire logic        parkLevelIn,
  input  wire logic [5:0]  dimThresholdIn,
  // Key matrix
  input  wire logic [5:0]  colIn,
  output logic      [4:0]  rowOut,
  // Display drivers
  output logic      [29:0] segmentOut,
  output logic      [1:0]  outputA
);
  typedef enum logic [0:0] {DV_IN = 1'b0, DV_OUT = 1'b1} vfdk_dstate_e;
  typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_RUN = 2'b01, SC_PAUSE = 2'b10} vfdk_scan_e;

  vfdk_dstate_e state_r;
  vfdk_scan_e   scan_r;
  logic [2:0]   linkS;
  logic [5:0]   colS;
  logic [5:0]   stepS;
  logic         parkS;
  logic         csD_r;
  logic         sclkD_r;
  logic         csRise;
  logic         csFall;
  logic         sclkRise;
  logic [63:0]  rxSh_r;
  logic [6:0]   rxCnt_r;
  logic [3:0]   mode;
  logic         cmdOk;
  logic         frameEnd;
  logic         enterOut;
  logic         stopCmd;
  logic [29:0]  txSh_r;
  logic [4:0]   txCnt_r;
  logic         devData_r;
  logic         devOe_r;
  logic [59:0]  disp_r;
  logic [10:0]  dim_r;
  logic         digMode_r;
  logic [7:0]   bitDiv_r;
  logic         bitTick;
  logic [5:0]   rowDiv_r;
  logic         rowTick;
  logic [2:0]   rowIdx_r;
  logic [4:0]   rowOut_r;
  logic [29:0]  keyMat_r;
  logic [5:0]   idleRef_r;
  logic         idleArm_r;
  logic         firstDone_r;
  logic         chgSeen_r;
  logic         keyInt_r;
  logic [10:0]  unitCnt_r;
  logic         output_a_r;
  logic [10:0]  onTime;
  logic         lit;
  logic [29:0]  seg_r;
  logic [1:0]   outA_r;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection
  vfdk_sync #(.W(3)) uSyncLink (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({link.cs, link.sclk, link.dataLine}),
    .q        (linkS)
  );
  vfdk_sync #(.W(13)) uSyncPins (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({parkLevelIn, dimThresholdIn, colIn}),
    .q        ({parkS, stepS, colS})
  );

  // Delayed copies for edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      csD_r   <= 1'b0;
      sclkD_r <= 1'b0;
    end else begin
      csD_r   <= linkS[2];
      sclkD_r <= linkS[1];
    end
  end

  assign csRise   = linkS[2] & ~csD_r;
  assign csFall   = ~linkS[2] & csD_r;
  assign sclkRise = linkS[2] & linkS[1] & ~sclkD_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command receiver
  assign mode     = rxSh_r[3:0];
  assign cmdOk    = vfdk_pkg::is_disp(mode) ? (rxCnt_r == 7'(vfdk_pkg::FRAME_LONG))
                                             : (rxCnt_r == 7'(vfdk_pkg::FRAME_SHORT)); // RULE_05
  assign frameEnd = csFall && state_r == DV_IN && cmdOk; // RULE_15
  assign enterOut = frameEnd && vfdk_pkg::is_ksout(mode); // RULE_14
  assign stopCmd  = frameEnd && vfdk_pkg::is_stop(mode); // RULE_14

  // Shift in on rising clock while selected
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxSh_r  <= '0;
      rxCnt_r <= '0;
    end else if (csRise) begin
      rxCnt_r <= '0;
    end else if (state_r == DV_IN && sclkRise) begin
      rxSh_r <= {rxSh_r[62:0], linkS[0]}; // RULE_15
      if (rxCnt_r != 7'(vfdk_pkg::FRAME_LONG)) rxCnt_r <= rxCnt_r + 7'h01;
    end
  end

  // Latch display, dimming mode and value at select fall
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      disp_r    <= '0;
      dim_r     <= '0;
      digMode_r <= 1'b0;
    end else if (frameEnd) begin
      if (vfdk_pkg::is_disp(mode)) disp_r <= rxSh_r[63:4]; // RULE_15
      case (mode)
        vfdk_pkg::MD_ANA, vfdk_pkg::MD_DISP_ANA: digMode_r <= 1'b0;
        vfdk_pkg::MD_DIG, vfdk_pkg::MD_DISP_DIG: digMode_r <= 1'b1;
        vfdk_pkg::MD_DIMDATA: begin
          dim_r     <= rxSh_r[vfdk_pkg::DIM_LSB +: vfdk_pkg::DIM_W]; // RULE_10
          digMode_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key data output
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r   <= DV_IN;
      devOe_r   <= 1'b0;
      devData_r <= 1'b0;
      txSh_r    <= '0;
      txCnt_r   <= '0;
    end else if (enterOut) begin
      state_r   <= DV_OUT;
      devOe_r   <= 1'b1; // RULE_01
      txSh_r    <= keyMat_r;
      devData_r <= keyMat_r[0]; // RULE_06
      txCnt_r   <= '0;
    end else if (state_r == DV_OUT) begin
      if (sclkRise && txCnt_r != 5'(vfdk_pkg::KEY_BITS)) begin
        txSh_r    <= txSh_r >> 1; // RULE_02
        devData_r <= txSh_r[1];
        txCnt_r   <= txCnt_r + 5'h01;
      end else if (csFall && txCnt_r == 5'(vfdk_pkg::KEY_BITS)) begin
        state_r <= DV_IN; // RULE_03
        devOe_r <= 1'b0; // RULE_16
      end
    end
  end

  assign link.devData = devData_r;
  assign link.devOe   = devOe_r;
  assign link.keyInt  = keyInt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bit-time and row-time enables
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bitDiv_r <= '0;
      rowDiv_r <= '0;
    end else begin
      bitDiv_r <= bitTick ? 8'h00 : bitDiv_r + 8'h01;
      if (bitTick) rowDiv_r <= rowDiv_r + 6'h01;
    end
  end

  assign bitTick = bitDiv_r == 8'(vfdk_pkg::BIT_CYC - 1);
  assign rowTick = bitTick && rowDiv_r == 6'(vfdk_pkg::ROW_UNITS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Key scanner
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scan_r      <= SC_IDLE;
      rowIdx_r    <= '0;
      rowOut_r    <= 5'h1F;
      keyMat_r    <= '0;
      idleRef_r   <= '0;
      idleArm_r   <= 1'b0;
      firstDone_r <= 1'b0;
      chgSeen_r   <= 1'b0;
      keyInt_r    <= 1'b0;
    end else if (stopCmd) begin
      keyInt_r  <= 1'b0;
      chgSeen_r <= 1'b0;
      idleArm_r <= 1'b0;
      rowOut_r  <= 5'h1F;
      scan_r    <= (scan_r == SC_RUN && chgSeen_r) ? SC_PAUSE : SC_IDLE; // RULE_07
    end else begin
      unique case (scan_r)
        SC_IDLE: if (rowTick) begin
          idleRef_r <= colS;
          idleArm_r <= 1'b1;
          if (idleArm_r && colS != idleRef_r) begin // RULE_13
            scan_r      <= SC_RUN;
            rowIdx_r    <= '0;
            rowOut_r    <= 5'h01;
            firstDone_r <= 1'b0;
          end
        end
        SC_RUN: if (rowTick) begin
          keyMat_r[int'(rowIdx_r) * vfdk_pkg::KEY_COLS +: vfdk_pkg::KEY_COLS] <= colS; // RULE_08
          if (firstDone_r &&
              colS != keyMat_r[int'(rowIdx_r) * vfdk_pkg::KEY_COLS +: vfdk_pkg::KEY_COLS])
            chgSeen_r <= 1'b1; // RULE_07
          if (rowIdx_r == 3'(vfdk_pkg::KEY_ROWS - 1)) begin
            rowIdx_r    <= '0;
            rowOut_r    <= 5'h01;
            firstDone_r <= 1'b1;
            keyInt_r    <= 1'b1; // RULE_13
          end else begin
            rowIdx_r <= rowIdx_r + 3'h1;
            rowOut_r <= rowOut_r << 1; // RULE_08
          end
        end
        SC_PAUSE: if (rowTick) begin
          scan_r      <= SC_RUN; // RULE_07
          rowIdx_r    <= '0;
          rowOut_r    <= 5'h01;
          firstDone_r <= 1'b0;
        end
        default: scan_r <= SC_IDLE;
      endcase
    end
  end

  assign rowOut = rowOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output_a period counter and dimming
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      unitCnt_r <= '0;
      output_a_r    <= 1'b0;
    end else if (bitTick) begin
      unitCnt_r <= unitCnt_r + 11'h001;
      if (unitCnt_r == vfdk_pkg::UNIT_MAX) output_a_r <= ~output_a_r;
    end
  end

  assign onTime = digMode_r ? ((dim_r > vfdk_pkg::DIG_MAX) ? vfdk_pkg::DIG_MAX : dim_r) // RULE_11
                            : vfdk_pkg::ana_count(stepS); // RULE_12
  assign lit    = parkS && unitCnt_r < onTime; // RULE_10

  // Driver outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seg_r  <= '0;
      outA_r <= '0;
    end else begin
      outA_r <= lit ? (output_a_r ? 2'h2 : 2'h1) : 2'h0;
      seg_r  <= lit ? (output_a_r ? disp_r[59:30] : disp_r[29:0]) : 30'h00000000; // RULE_09
    end
  end

  assign segmentOut = seg_r;
  assign outputA    = outA_r;
endmodule

// [vfdk_host.sv]
// Controller end: APB registers, frame sender and key reader
`timescale 1ns/1ps
module vfdk_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Serial link
  vfdk_link_if.host        link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SEND = 3'b001, H_END = 3'b010,
    H_GAP  = 3'b011, H_RECV = 3'b100, H_FIN = 3'b101
  } vfdk_hstate_e;

  vfdk_hstate_e st_r;
  logic [1:0]   linkS;
  logic         keyIntD_r;
  logic         wrEn;
  logic         go;
  logic [31:0]  rdVal;
  logic         hit;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  logic [31:0]  dispLo_r;
  logic [27:0]  dispHi_r;
  logic [1:0]   status_r;
  logic [1:0]   mask_r;
  logic         irq_r;
  logic [29:0]  keys_r;
  logic [3:0]   cmdMode;
  logic [63:0]  txSh_r;
  logic [6:0]   cnt_r;
  logic         rdNext_r;
  logic [7:0]   div_r;
  logic         tick;
  logic         cs_r;
  logic         sclk_r;
  logic         dout_r;
  logic         oe_r;
  logic         doneEvt_r;
  logic [1:0]   setEv;
  logic [1:0]   clrEv;

  ////////////////////////////////////////////////////////////////////////////
  // Link input synchronisers
  vfdk_sync #(.W(2)) uSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({link.keyInt, link.dataLine}),
    .q        (linkS)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then completion
  assign wrEn    = psel && penable && pready_r && pwrite;
  assign cmdMode = pwdata[3:0];
  assign go      = wrEn && paddr == vfdk_pkg::REG_CMD && st_r == H_IDLE;

  // Read mux and address decode
  always_comb begin
    hit   = 1'b1;
    rdVal = 32'h00000000;
    case (paddr)
      vfdk_pkg::REG_CMD:    rdVal = 32'h00000000;
      vfdk_pkg::REG_STATUS: rdVal = {23'h000000, st_r != H_IDLE, 6'h00, status_r};
      vfdk_pkg::REG_MASK:   rdVal = {30'h00000000, mask_r};
      vfdk_pkg::REG_DISPLO: rdVal = dispLo_r;
      vfdk_pkg::REG_DISPHI: rdVal = {4'h0, dispHi_r};
      vfdk_pkg::REG_KEYS:   rdVal = {2'h0, keys_r};
      default:              hit   = 1'b0;
    endcase
  end

  // Bus answer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      prdata_r  <= (psel && !pwrite) ? rdVal : 32'h00000000;
      pslverr_r <= psel && penable && !pready_r && !hit;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Writable registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dispLo_r <= '0;
      dispHi_r <= '0;
      mask_r   <= '0;
    end else if (wrEn) begin
      if (paddr == vfdk_pkg::REG_DISPLO) dispLo_r <= pwdata;
      if (paddr == vfdk_pkg::REG_DISPHI) dispHi_r <= pwdata[27:0];
      if (paddr == vfdk_pkg::REG_MASK) mask_r <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over write-one clear
  assign setEv = {linkS[1] & ~keyIntD_r, doneEvt_r};
  assign clrEv = (wrEn && paddr == vfdk_pkg::REG_STATUS) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      keyIntD_r <= 1'b0;
      status_r  <= '0;
      irq_r     <= 1'b0;
    end else begin
      keyIntD_r <= linkS[1];
      status_r  <= setEv | (status_r & ~clrEv);
      irq_r     <= |(status_r & mask_r);
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Half-period divider for the serial clock
  always_ff @(posedge core_clk) begin
    if (!rst_n || st_r == H_IDLE) div_r <= '0;
    else div_r <= tick ? 8'h00 : div_r + 8'h01;
  end

  assign tick = div_r == 8'(vfdk_pkg::LINK_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r      <= H_IDLE;
      txSh_r    <= '0;
      cnt_r     <= '0;
      rdNext_r  <= 1'b0;
      cs_r      <= 1'b0;
      sclk_r    <= 1'b0;
      dout_r    <= 1'b0;
      oe_r      <= 1'b0;
      keys_r    <= '0;
      doneEvt_r <= 1'b0;
    end else begin
      doneEvt_r <= 1'b0;
      unique case (st_r)
        H_IDLE: if (go) begin
          if (vfdk_pkg::is_disp(cmdMode)) begin
            txSh_r <= {dispHi_r, dispLo_r, cmdMode};
            dout_r <= dispHi_r[27];
            cnt_r  <= 7'(vfdk_pkg::FRAME_LONG);
          end else begin
            txSh_r <= {1'b0, pwdata[14:4], cmdMode, 48'h000000000000};
            dout_r <= 1'b0;
            cnt_r  <= 7'(vfdk_pkg::FRAME_SHORT); // RULE_05
          end
          rdNext_r <= vfdk_pkg::is_ksout(cmdMode); // RULE_04
          cs_r     <= 1'b1;
          oe_r     <= 1'b1;
          st_r     <= H_SEND;
        end
        H_SEND: if (tick) begin
          sclk_r <= ~sclk_r;
          if (sclk_r) begin
            txSh_r <= txSh_r << 1;
            dout_r <= txSh_r[62];
            cnt_r  <= cnt_r - 7'h01;
            if (cnt_r == 7'h01) st_r <= H_END;
          end
        end
        H_END: if (tick) begin
          cs_r      <= 1'b0;
          oe_r      <= 1'b0;
          st_r      <= rdNext_r ? H_GAP : H_IDLE;
          doneEvt_r <= !rdNext_r;
        end
        H_GAP: if (tick) begin
          cs_r  <= 1'b1;
          cnt_r <= 7'(vfdk_pkg::KEY_BITS); // RULE_06
          st_r  <= H_RECV;
        end
        H_RECV: if (tick) begin
          sclk_r <= ~sclk_r; // RULE_02
          if (!sclk_r) begin
            keys_r <= {linkS[0], keys_r[29:1]}; // RULE_06
          end else begin
            cnt_r <= cnt_r - 7'h01;
            if (cnt_r == 7'h01) st_r <= H_FIN;
          end
        end
        H_FIN: if (tick) begin
          cs_r      <= 1'b0;
          st_r      <= H_IDLE;
          doneEvt_r <= 1'b1;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.cs       = cs_r;
  assign link.sclk     = sclk_r;
  assign link.hostData = dout_r;
  assign link.hostOe   = oe_r;
endmodule

// [vfdk_link_if.sv]
// Four-wire serial link between controller and display device
`timescale 1ns/1ps
interface vfdk_link_if;
  logic cs;
  logic sclk;
  logic hostData;
  logic hostOe;
  logic devData;
  logic devOe;
  logic keyInt;
  logic dataLine;

  // Shared data line, pulled high when nobody drives
  assign dataLine = devOe ? devData : (hostOe ? hostData : 1'b1);

  modport dev (input cs, input sclk, input dataLine, output devData, output devOe,
               output keyInt);
  modport host (output cs, output sclk, output hostData, output hostOe,
                input dataLine, input keyInt);
endinterface

// [vfdk_link_props.sv]
// Link checks between the controller end and the display end
`timescale 1ns/1ps
module vfdk_link_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic cs,
  input wire logic sclk,
  input wire logic hostData,
  input wire logic hostOe,
  input wire logic devOe
);
  logic [6:0] riseCnt_r;
  logic       sclkOld_r;

  ////////////////////////////////
  // Clock rises counted inside each select window
  always_ff @(posedge core_clk) begin
    sclkOld_r <= sclk;
    if (!rst_n || !cs) begin
      riseCnt_r <= 7'h00;
    end else if (sclk && !sclkOld_r) begin
      riseCnt_r <= riseCnt_r + 7'h01;
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////
  drive_clash_a:
    assert property (!(hostOe && devOe)) else $error("both ends drive data");
  turn_out_a:
    assert property ($rose(devOe) |-> !cs) else $error("turned round inside frame");
  hold_out_a:
    assert property (devOe && cs |=> devOe) else $error("output dropped in readout");
  pin_release_a:
    assert property (devOe && $fell(cs) |-> ##[1:8] !devOe) else $error("data pin held");
  read_len_a:
    assert property (devOe && $fell(cs) |-> riseCnt_r == 7'h1E) else $error("readout not 30");
  rise_cap_a:
    assert property (cs && devOe |-> riseCnt_r <= 7'h1E) else $error("too many clocks");
  cmd_len_a:
    assert property (!devOe && $fell(cs) |-> riseCnt_r == 7'h10 || riseCnt_r == 7'h40)
      else $error("bad frame length");
  sclk_framed_a:
    assert property ($changed(sclk) |-> cs) else $error("clock outside frame");
  data_hold_a:
    assert property (cs && hostOe && sclk && $past(sclk) |-> $stable(hostData))
      else $error("data moved while clock high");
endmodule

// [vfdk_pkg.sv]
// Shared constants, mode codes and helpers for the keyscan display link
package vfdk_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS        = 8;
  localparam int BIT_TIME_NS   = 1200;
  localparam int BIT_CYC       = (BIT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINK_HALF_NS  = 128;
  localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_NS;
  localparam int ROW_UNITS     = 64;

  ////////////////////////////////////////////////////////////////////////////
  // Frame and matrix sizes
  localparam int KEY_BITS    = 30;
  localparam int KEY_COLS    = 6;
  localparam int KEY_ROWS    = 5;
  localparam int SEG_N       = 30;
  localparam int DISP_BITS   = 60;
  localparam int FRAME_LONG  = 64;
  localparam int FRAME_SHORT = 16;
  localparam int MODE_W      = 4;
  localparam int DIM_W       = 11;
  localparam int DIM_LSB     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Dimming limits
  localparam logic [10:0] DIG_MAX  = 11'h7F0;
  localparam logic [10:0] UNIT_MAX = 11'h7FF;
  localparam logic [10:0] ANA_TOP  = 11'h100;

  ////////////////////////////////////////////////////////////////////////////
  // Controller register map and status bits
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK   = 8'h08;
  localparam logic [7:0] REG_DISPLO = 8'h0C;
  localparam logic [7:0] REG_DISPHI = 8'h10;
  localparam logic [7:0] REG_KEYS   = 8'h14;
  localparam int STAT_DONE = 0;
  localparam int STAT_KEY  = 1;
  localparam int STAT_BUSY = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Mode field codes
  typedef enum logic [3:0] {
    MD_DISP       = 4'h0,
    MD_DIMDATA    = 4'h1,
    MD_DISP_ANA   = 4'h2,
    MD_ANA        = 4'h3,
    MD_DISP_DIG   = 4'h4,
    MD_DIG        = 4'h5,
    MD_DISP_KSOUT = 4'h6,
    MD_KSOUT      = 4'h7,
    MD_KSOUT_STOP = 4'h8,
    MD_KSTOP      = 4'h9
  } vfdk_mode_e;

  // Modes that carry a 64-bit display frame
  function automatic logic is_disp(input logic [3:0] m);
    return m == MD_DISP || m == MD_DISP_ANA || m == MD_DISP_DIG || m == MD_DISP_KSOUT;
  endfunction

  // Modes that turn the data line round for a key read
  function automatic logic is_ksout(input logic [3:0] m);
    return m == MD_KSOUT || m == MD_DISP_KSOUT || m == MD_KSOUT_STOP || m == MD_KSTOP;
  endfunction

  // Modes that stop the key scan
  function automatic logic is_stop(input logic [3:0] m);
    return m == MD_KSOUT_STOP || m == MD_KSTOP;
  endfunction

  // Analog step number to on-time counts out of 2048
  function automatic logic [10:0] ana_count(input logic [5:0] step);
    logic [10:0] s;
    s = {5'h00, step};
    if (step == 6'h00) return 11'h000;
    else if (step <= 6'h0C) return s + 11'h00C;
    else if (step <= 6'h18) return s << 1;
    else if (step <= 6'h24) return (s << 2) - 11'h030;
    else if (step <= 6'h30) return (s << 3) - 11'h0C0;
    else if (step <= 6'h34) return (s << 4) - 11'h240;
    else return ANA_TOP;
  endfunction

endpackage

// [vfdk_sync.sv]
// Two-flop synchroniser for signals from outside the core clock domain
`timescale 1ns/1ps
module vfdk_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
